/* File: ext_bus_misc_ctrl.sv */
// miscellaneous control registers of the multiplexed external bus interface
//
// Summary of operation
// - registers sit at fixed offsets from a relocatable module base
// - expanded and peripheral modes drop registers from map; accesses go external
// - pulls act per port and only on pins set as inputs
// - pull register read and write anytime while mapped; no effect on outputs
// - pull bit 7 enables pulls on all port K inputs
// - pull bit 4 covers port E pins 7 and 4:0; pins 5,6 pulled in reset only
// - pull bit 1 covers port B inputs, bit 0 port A inputs
// - drive bits 7,4,1,0 select reduced drive for ports K,E,B,A
// - reduced drive applies whatever pin function is active
// - stretch clear runs bus clock free; set stretches high and parks low on internal accesses that are not visible
// - stretch bit written once in normal/emulation, anytime in special modes
// - stretch bit has no influence in single-chip modes
// - reserved offset 0x000F reads zero and ignores writes
// - irq bit 7 selects low level or falling edge sensing
// - edge mode latches falling edges until reset or service
// - edge select write anytime in special modes, once in normal/emulation
// - irq bit 6 connects the pin to interrupt logic, write anytime
// - with pin disconnected the edge latch is held cleared
// - mode writes blocked while secured
// - special to normal single chip leaves one mode write; to expanded leaves none
// - write permission is checked against the current three-bit mode
// - mode-related writes take effect one cycle after the write
`timescale 1ns/1ps
`include "ext_bus_misc_map.svh"
module ext_bus_misc_ctrl #(
  parameter int ADDR_W = 10,
  parameter int PORTA_W = 8,
  parameter int PORTB_W = 8,
  parameter int PORTE_W = 8,
  parameter int PORTK_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic regHit,
  output logic extEcho,
  input wire ext_bus_misc_pkg::op_mode_t strapMode,
  input wire logic secured,
  input wire logic [PORTA_W-1:0] dirPortA,
  input wire logic [PORTB_W-1:0] dirPortB,
  input wire logic [PORTE_W-1:0] dirPortE,
  input wire logic [PORTK_W-1:0] dirPortK,
  output logic [PORTA_W-1:0] pullPortA,
  output logic [PORTB_W-1:0] pullPortB,
  output logic [PORTE_W-1:0] pullPortE,
  output logic [PORTK_W-1:0] pullPortK,
  output ext_bus_misc_pkg::port_ctl_t lowDrive,
  input wire logic extAccess,
  input wire logic stretchAccess,
  input wire logic visibleAccess,
  input wire logic phaseHigh,
  output logic busClk,
  input wire logic irqPin_b,
  input wire logic irqService,
  output logic irqRequest,
  output ext_bus_misc_pkg::op_mode_t curMode
);
  import ext_bus_misc_pkg::*;

  op_mode_t mode_q;
  logic modeLoaded_q;
  logic modeWritesLeft_q;
  logic [7:0] pull_q;
  logic [7:0] drive_q;
  logic stretch_q;
  logic stretchWritten_q;
  logic irqEdge_q;
  logic irqEdgeWritten_q;
  logic irqConnect_q;
  logic irqPinPrev_q;
  logic edgeLatch_q;
  logic inReset_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [9:0] off;
  logic specialMode;
  logic singleChip;
  logic mapped;
  logic wrPull;
  logic wrDrive;
  logic wrBusClk;
  logic wrIrq;
  logic wrMode;
  logic modeLegal;
  op_mode_t newMode;

  assign off = 10'(regAddr);
  assign specialMode = (mode_q == MODE_SPECIAL_SINGLE) || (mode_q == MODE_SPECIAL_TEST)
                       || (mode_q == MODE_PERIPHERAL);
  assign singleChip = (mode_q == MODE_SPECIAL_SINGLE) || (mode_q == MODE_NORMAL_SINGLE);
  // only single-chip and special test keep the bank in the internal map
  assign mapped = (mode_q == MODE_SPECIAL_SINGLE) || (mode_q == MODE_NORMAL_SINGLE)
                  || (mode_q == MODE_SPECIAL_TEST);
  assign regHit = mapped && ((off == `OFF_PULL_CTRL) || (off == `OFF_DRIVE_CTRL)
                  || (off == `OFF_BUS_CLK_CTRL) || (off == `OFF_RESERVED)
                  || (off == `OFF_IRQ_CTRL) || (off == `OFF_MODE_CTRL));
  assign extEcho = !mapped && (regWr || regRd) && ((off == `OFF_PULL_CTRL) || (off == `OFF_DRIVE_CTRL)
                   || (off == `OFF_BUS_CLK_CTRL) || (off == `OFF_RESERVED)
                   || (off == `OFF_IRQ_CTRL) || (off == `OFF_MODE_CTRL));
  // writes land only while mapped; echoed ones touch nothing here
  assign wrPull = regWr && mapped && (off == `OFF_PULL_CTRL);
  assign wrDrive = regWr && mapped && (off == `OFF_DRIVE_CTRL);
  assign wrBusClk = regWr && mapped && (off == `OFF_BUS_CLK_CTRL);
  assign wrIrq = regWr && mapped && (off == `OFF_IRQ_CTRL);
  assign wrMode = regWr && mapped && (off == `OFF_MODE_CTRL);
  assign newMode = op_mode_t'(regWdata[`MODE_LSB +: 3]);
  assign curMode = mode_q;

  // mode write permission by current mode
  always_comb
  begin
    modeLegal = 1'b0;
    case (mode_q)
      MODE_SPECIAL_SINGLE, MODE_SPECIAL_TEST:
        modeLegal = (newMode != MODE_PERIPHERAL);
      MODE_NORMAL_SINGLE:
        modeLegal = modeWritesLeft_q && ((newMode == MODE_NORMAL_NARROW) || (newMode == MODE_NORMAL_WIDE)
                    || (newMode == MODE_NORMAL_SINGLE));
      default:
        modeLegal = 1'b0;
    endcase
    if (secured)
    begin
      modeLegal = 1'b0;
    end
  end

  // strap caught after reset release, never under the asynchronous reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_q <= MODE_SPECIAL_SINGLE;
      modeLoaded_q <= 1'b0;
      modeWritesLeft_q <= 1'b0;
    end
    else if (!modeLoaded_q)
    begin
      mode_q <= strapMode;
      modeLoaded_q <= 1'b1;
      modeWritesLeft_q <= (strapMode == MODE_NORMAL_SINGLE);
    end
    else if (wrMode && modeLegal)
    begin
      mode_q <= newMode;
      if (mode_q == MODE_NORMAL_SINGLE)
      begin
        modeWritesLeft_q <= 1'b0;
      end
      else
      begin
        modeWritesLeft_q <= (newMode == MODE_NORMAL_SINGLE);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pull_q <= `PULL_RESET;
    end
    else if (wrPull)
    begin
      pull_q <= regWdata & `PULL_MASK;
    end
  end

  // masking keeps unimplemented bits at zero for readback
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drive_q <= `DRIVE_RESET;
    end
    else if (wrDrive)
    begin
      drive_q <= regWdata & `DRIVE_MASK;
    end
  end

  // a special-mode write also uses up the single normal-mode write
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stretch_q <= 1'b0;
      stretchWritten_q <= 1'b0;
    end
    else if (wrBusClk && (specialMode || !stretchWritten_q))
    begin
      stretch_q <= regWdata[`BIT_STRETCH];
      stretchWritten_q <= 1'b1;
    end
  end

  // connect stays writable in every mapped mode; only edge select is once-only
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqEdge_q <= 1'b0;
      irqEdgeWritten_q <= 1'b0;
      irqConnect_q <= 1'b1;
    end
    else if (wrIrq)
    begin
      irqConnect_q <= regWdata[`BIT_IRQ_CONNECT];
      if (specialMode || !irqEdgeWritten_q)
      begin
        irqEdge_q <= regWdata[`BIT_IRQ_EDGE];
        irqEdgeWritten_q <= 1'b1;
      end
    end
  end

  // falling edge latch; a new edge wins over a service in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqPinPrev_q <= 1'b1;
      edgeLatch_q <= 1'b0;
    end
    else
    begin
      irqPinPrev_q <= irqPin_b;
      if (!irqConnect_q)
      begin
        edgeLatch_q <= 1'b0;
      end
      else if (irqEdge_q && irqPinPrev_q && !irqPin_b)
      begin
        edgeLatch_q <= 1'b1;
      end
      else if (irqService)
      begin
        edgeLatch_q <= 1'b0;
      end
    end
  end

  // level mode reads the pin directly, so no cycle of delay
  assign irqRequest = irqConnect_q && (irqEdge_q ? edgeLatch_q : !irqPin_b);

  // port E pins 5 and 6 are pulled only until the first edge after reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inReset_q <= 1'b1;
    end
    else
    begin
      inReset_q <= 1'b0;
    end
  end

  // pulls land only on input pins; outputs never see them
  assign pullPortK = pull_q[`BIT_PORT_K] ? ~dirPortK : '0;
  assign pullPortB = pull_q[`BIT_PORT_B] ? ~dirPortB : '0;
  assign pullPortA = pull_q[`BIT_PORT_A] ? ~dirPortA : '0;

  genvar i;
  generate
    for (i = 0; i < PORTE_W; i = i + 1)
    begin : g_pullE
      if (i == 5 || i == 6)
      begin : g_rst
        assign pullPortE[i] = inReset_q && !dirPortE[i];
      end
      else
      begin : g_bit
        assign pullPortE[i] = pull_q[`BIT_PORT_E] && !dirPortE[i];
      end
    end
  endgenerate

  // drive selection ignores pin function on purpose
  assign lowDrive.portK = drive_q[`BIT_PORT_K];
  assign lowDrive.portE = drive_q[`BIT_PORT_E];
  assign lowDrive.portB = drive_q[`BIT_PORT_B];
  assign lowDrive.portA = drive_q[`BIT_PORT_A];

  // bus clock shaping from the core's phase
  always_comb
  begin
    busClk = phaseHigh;
    if (stretch_q && !singleChip)
    begin
      if (extAccess && stretchAccess)
      begin
        busClk = 1'b1;
      end
      else if (!extAccess && !visibleAccess)
      begin
        busClk = 1'b0;
      end
    end
  end

  // read mux; a strobe that misses the bank gives zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (regRd && mapped)
    begin
      case (off)
        `OFF_PULL_CTRL: rdata_d = pull_q;
        `OFF_DRIVE_CTRL: rdata_d = drive_q;
        `OFF_BUS_CLK_CTRL: rdata_d = {7'h00, stretch_q};
        `OFF_IRQ_CTRL: rdata_d = {irqEdge_q, irqConnect_q, 6'h00};
        `OFF_MODE_CTRL: rdata_d = {mode_q, 5'h00};
        `OFF_RESERVED: rdata_d = 8'h00;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // data stand for one cycle, then fall back to zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
endmodule

/* File: ext_bus_misc_map.svh */
// offsets, field positions and reset values of the external bus misc control registers
`ifndef EXT_BUS_MISC_MAP_SVH
`define EXT_BUS_MISC_MAP_SVH
`define OFF_PULL_CTRL 10'h00C
`define OFF_DRIVE_CTRL 10'h00D
`define OFF_BUS_CLK_CTRL 10'h00E
`define OFF_RESERVED 10'h00F
`define OFF_IRQ_CTRL 10'h01E
`define OFF_MODE_CTRL 10'h00B
`define BIT_PORT_K 7
`define BIT_PORT_E 4
`define BIT_PORT_B 1
`define BIT_PORT_A 0
`define BIT_STRETCH 0
`define BIT_IRQ_EDGE 7
`define BIT_IRQ_CONNECT 6
`define MODE_LSB 5
`define PULL_MASK 8'h93
`define DRIVE_MASK 8'h93
`define BUS_CLK_MASK 8'h01
`define IRQ_MASK 8'hC0
`define PULL_RESET 8'h90
`define DRIVE_RESET 8'h00
`define BUS_CLK_RESET 8'h00
`define IRQ_RESET 8'h40
`endif

/* File: ext_bus_misc_pkg.sv */
// types of the external bus misc control registers
package ext_bus_misc_pkg;
  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'b000,
    MODE_EMUL_NARROW = 3'b001,
    MODE_SPECIAL_TEST = 3'b010,
    MODE_EMUL_WIDE = 3'b011,
    MODE_NORMAL_SINGLE = 3'b100,
    MODE_NORMAL_NARROW = 3'b101,
    MODE_PERIPHERAL = 3'b110,
    MODE_NORMAL_WIDE = 3'b111
  } op_mode_t;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic portK;
    logic portE;
    logic portB;
    logic portA;
  } port_ctl_t;
endpackage

/* File: ext_bus_misc_pins.sv */
// pin and core bus status model facing the misc control registers
`timescale 1ns/1ps
module ext_bus_misc_pins (
  input wire logic sys_clk,
  input wire logic irqLow,
  output logic irqPin_b,
  output logic phaseHigh,
  output logic extAccess,
  output logic stretchAccess,
  output logic visibleAccess
);
  logic [4:0] phaseCnt_q = 5'h00;
  always @(posedge sys_clk)
    phaseCnt_q <= phaseCnt_q + 5'h01;
  // pin follows the bench level; bench moves it just after a rising edge
  assign irqPin_b = !irqLow;
  assign phaseHigh = phaseCnt_q[0];
  assign extAccess = phaseCnt_q[2];
  assign stretchAccess = phaseCnt_q[3];
  assign visibleAccess = phaseCnt_q[4];
endmodule

/* File: ext_bus_misc_ctrl_sva.sv */
// assertion checker for the misc control registers
`timescale 1ns/1ps
module ext_bus_misc_ctrl_sva
  import ext_bus_misc_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int PORTA_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic regHit,
  input wire logic extEcho,
  input wire logic secured,
  input wire logic [PORTA_W-1:0] dirPortA,
  input wire logic [PORTA_W-1:0] pullPortA,
  input wire ext_bus_misc_pkg::port_ctl_t lowDrive,
  input wire logic phaseHigh,
  input wire logic busClk,
  input wire logic irqRequest,
  input wire ext_bus_misc_pkg::op_mode_t curMode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_RSVD_ZERO: assert property (regRd && regAddr == 10'h00F |=> regRdata == 8'h00)
    else $error("reserved read not zero");
  // idle gap keeps a second write from changing the expected value
  AST_PULL_READBACK: assert property (regWr && regHit && regAddr == 10'h00C ##1 !regWr
    ##1 regRd && regAddr == 10'h00C |=> regRdata == ($past(regWdata, 3) & 8'h93))
    else $error("pull readback");
  AST_PULL_FOLLOWS: assert property (regWr && regHit && regAddr == 10'h00C
    |=> pullPortA == ({PORTA_W{$past(regWdata[0])}} & ~dirPortA)) else $error("port a pull");
  AST_LOW_DRIVE: assert property (regWr && regHit && regAddr == 10'h00D
    |=> lowDrive == $past({regWdata[7], regWdata[4], regWdata[1], regWdata[0]})) else $error("low drive");
  AST_ECHO_UNMAPPED: assert property (extEcho |-> (regWr || regRd)
    && !(curMode inside {MODE_SPECIAL_SINGLE, MODE_SPECIAL_TEST, MODE_NORMAL_SINGLE})) else $error("echo when mapped");
  AST_ECHO_READ_ZERO: assert property (regRd && extEcho |=> regRdata == 8'h00) else $error("echo read data");
  AST_SINGLE_FREE_CLK: assert property (curMode inside {MODE_SPECIAL_SINGLE, MODE_NORMAL_SINGLE}
    |-> busClk == phaseHigh) else $error("bus clock shaped in single chip");
  AST_SECURE_HOLD: assert property (secured && regWr && regAddr == 10'h00B |=> $stable(curMode) [*2])
    else $error("mode moved while secured");
  AST_IRQ_DISCONNECT: assert property (regWr && regHit && regAddr == 10'h01E && !regWdata[6]
    |=> !irqRequest) else $error("request while disconnected");
  cover property (regWr && regHit && regAddr == 10'h00C);
  cover property (extEcho && regRd);
  cover property ($rose(irqRequest));
endmodule
bind ext_bus_misc_ctrl ext_bus_misc_ctrl_sva #(.ADDR_W(ADDR_W), .PORTA_W(PORTA_W)) sva (.sys_clk, .rst_b,
  .regAddr, .regWdata, .regWr, .regRd, .regRdata, .regHit, .extEcho, .secured, .dirPortA, .pullPortA,
  .lowDrive, .phaseHigh, .busClk, .irqRequest, .curMode);

/* File: ext_bus_misc_ctrl_tb.sv */
// self-checking bench for the misc control registers
`timescale 1ns/1ps
module ext_bus_misc_ctrl_tb;
  import ext_bus_misc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic secured = 1'b0;
  logic irqService = 1'b0;
  logic irqLow = 1'b0;
  logic rdPend = 1'b0;
  logic expClk;
  logic [7:0] dirPortA = 8'h00, dirPortB = 8'h00, dirPortE = 8'h00, dirPortK = 8'h00;
  logic [7:0] regRdata, pullPortA, pullPortB, pullPortE, pullPortK, v;
  logic regHit, extEcho, busClk, irqRequest, irqPin_b, phaseHigh, extAccess, stretchAccess, visibleAccess;
  port_ctl_t lowDrive;
  op_mode_t curMode;
  op_mode_t strapMode = MODE_SPECIAL_SINGLE;
  logic [7:0] expQ[$];
  int seed = 66102;
  int mismatches = 0;
  int checkCount = 0;
  logic [9:0] offs [5] = '{10'h00C, 10'h00D, 10'h00E, 10'h00F, 10'h01E};
  logic [7:0] rstv [5] = '{8'h90, 8'h00, 8'h00, 8'h00, 8'h40};
  logic [7:0] msk [5] = '{8'h93, 8'h93, 8'h01, 8'h00, 8'hC0};
  always #25 sys_clk = !sys_clk;
  ext_bus_misc_ctrl dut (.sys_clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .regHit, .extEcho,
    .strapMode, .secured, .dirPortA, .dirPortB, .dirPortE, .dirPortK, .pullPortA, .pullPortB, .pullPortE,
    .pullPortK, .lowDrive, .extAccess, .stretchAccess, .visibleAccess, .phaseHigh, .busClk, .irqPin_b,
    .irqService, .irqRequest, .curMode);
  ext_bus_misc_pins pins (.sys_clk, .irqLow, .irqPin_b, .phaseHigh, .extAccess, .stretchAccess, .visibleAccess);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    expQ.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  // read data stand one cycle only, so the watcher looks mid-cycle
  always @(posedge sys_clk)
    rdPend <= regRd;
  always @(negedge sys_clk)
    if (rdPend)
      chk(regRdata, expQ.pop_front());
  task automatic irqWait(input int n, input logic e);
    repeat (n) @(negedge sys_clk);
    chk({7'h00, irqRequest}, {7'h00, e});
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 5; i++)
      rd(offs[i], rstv[i]);
    $display("reset values done");
    repeat (3)
    begin
      v = 8'($random(seed));
      for (int i = 0; i < 5; i++)
      begin
        acc(1'b1, offs[i], v);
        rd(offs[i], v & msk[i]);
      end
      {dirPortK, dirPortE, dirPortB, dirPortA} <= $random(seed);
      @(negedge sys_clk);
      chk(pullPortA, {8{v[0]}} & ~dirPortA);
      chk(pullPortB, {8{v[1]}} & ~dirPortB);
      chk(pullPortK, {8{v[7]}} & ~dirPortK);
      chk(pullPortE & 8'h9F, {8{v[4]}} & ~dirPortE & 8'h9F);
      chk({4'h0, lowDrive}, {4'h0, v[7], v[4], v[1], v[0]});
    end
    $display("register access done");
    acc(1'b1, 10'h01E, 8'hC0);
    irqLow <= 1'b1;
    irqWait(3, 1'b1);
    @(posedge sys_clk);
    irqLow <= 1'b0;
    irqWait(3, 1'b1);
    @(posedge sys_clk);
    irqService <= 1'b1;
    @(posedge sys_clk);
    irqService <= 1'b0;
    irqWait(2, 1'b0);
    acc(1'b1, 10'h01E, 8'h40);
    irqLow <= 1'b1;
    irqWait(2, 1'b1);
    acc(1'b1, 10'h01E, 8'h00);
    irqWait(2, 1'b0);
    @(posedge sys_clk);
    irqLow <= 1'b0;
    $display("interrupt pin done");
    acc(1'b1, 10'h00E, 8'h01);
    secured <= 1'b1;
    acc(1'b1, 10'h00B, 8'h80);
    repeat (2) @(negedge sys_clk);
    chk({5'h00, curMode}, 8'h00);
    @(posedge sys_clk);
    secured <= 1'b0;
    acc(1'b1, 10'h00B, 8'h80);
    repeat (2) @(negedge sys_clk);
    chk({5'h00, curMode}, 8'h04);
    acc(1'b1, 10'h00E, 8'h01);
    acc(1'b1, 10'h00E, 8'h00);
    rd(10'h00E, 8'h01);
    acc(1'b1, 10'h01E, 8'hC0);
    rd(10'h01E, 8'h40);
    acc(1'b1, 10'h00B, 8'hA0);
    repeat (2) @(negedge sys_clk);
    chk({5'h00, curMode}, 8'h05);
    rd(10'h00C, 8'h00);
    repeat (2) @(negedge sys_clk);
    // the pin model walks every status combination in 32 cycles
    for (int i = 0; i < 32; i++)
    begin
      @(negedge sys_clk);
      expClk = (extAccess && stretchAccess) || (phaseHigh && (extAccess || visibleAccess));
      chk({7'h00, busClk}, {7'h00, expClk});
    end
    $display("mode control done");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(negedge sys_clk);
    chk(pullPortE & 8'h60, ~dirPortE & 8'h60);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(pullPortE & 8'h60, 8'h00);
    rd(10'h00C, 8'h90);
    rd(10'h00E, 8'h00);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
